// ---- rlec_regs.svh ----
// Purpose: register offsets, field values, reset values and limits of the line and error config
// Assumes: byte addresses on an 8-bit command port, 32-bit data
// Notes: frequencies are held in units of 10 Hz (0.01 kHz)
`ifndef RLEC_REGS_SVH
`define RLEC_REGS_SVH
`define RLEC_ADR_W 8
`define RLEC_ADR_MODEM_READY 8'h00
`define RLEC_ADR_SET_READY 8'h04
`define RLEC_ADR_TERM_READY 8'h08
`define RLEC_ADR_ERR_INSERT 8'h0c
`define RLEC_ADR_SYNTH_RATE 8'h10
`define RLEC_ADR_TIMING 8'h14
`define RLEC_ADR_PATTERN 8'h18
`define RLEC_ADR_MSG_END 8'h1c
`define RLEC_ADR_ROLE 8'h20
`define RLEC_ADR_ERR_BUF 8'h24
`define RLEC_INS_CODE_OFF 2'h0
`define RLEC_INS_CODE_SINGLE 2'h1
`define RLEC_INS_CODE_RATE 2'h2
`define RLEC_FREQ_W 24
`define RLEC_FREQ_MIN 24'h000005
`define RLEC_FREQ_MAX 24'h16e360
`define RLEC_FREQ_RST 24'h0003c0
`define RLEC_ASYNC_FREQ_MAX 24'h0f4240
`define RLEC_PAT_SYNC_ONLY 2'h3
`define RLEC_RATE_BITS 1000
`define RLEC_EBUF_DEPTH 8
`define RLEC_EBUF_VALID_BIT 8
`endif

// ---- rlec_pkg.sv ----
// Purpose: shared types of the line and error config block
// Assumes: nothing beyond the header
// Notes: insertion modes are one-hot
package rlec_pkg;
    typedef enum logic [2:0] {
        RLEC_INS_OFF = 3'b001,
        RLEC_INS_SINGLE = 3'b010,
        RLEC_INS_RATE = 3'b100
    } rlec_ins_type;
    typedef enum logic [1:0] {
        RLEC_ERR_NONE = 2'h0,
        RLEC_ERR_ROLE = 2'h1,
        RLEC_ERR_PARAM = 2'h2,
        RLEC_ERR_CONTENTION = 2'h3
    } rlec_err_type;
endpackage

// ---- rlec_evt_if.sv ----
// Purpose: carries error-buffer and insertion-control signals between the block's modules
// Assumes: one clock domain
// Notes: core drives push, pop and insertion control, buffer and inserter consume; buffer drives head code and valid back to core
`timescale 1ns/10ps
`default_nettype none
interface rlec_evt_if;
    import rlec_pkg::*;
    logic push;
    rlec_err_type push_code;
    logic pop;
    rlec_err_type head_code;
    logic head_valid;
    rlec_ins_type ins_mode;
    logic single_pulse;
    modport core (output push, push_code, pop, ins_mode, single_pulse,
        input head_code, head_valid);
    modport ebuf (input push, push_code, pop, output head_code, head_valid);
    modport inj (input ins_mode, single_pulse);
endinterface
`default_nettype wire

// ---- rlec_err_buf.sv ----
// Purpose: small error buffer, oldest entry always held in a register
// Assumes: pop only while not empty
// Notes: a full buffer drops new entries; oldest errors are the useful ones
`timescale 1ns/10ps
`default_nettype none
`include "rlec_regs.svh"
module rlec_err_buf #(
    parameter int DEPTH = `RLEC_EBUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    rlec_evt_if.ebuf ev
);
    import rlec_pkg::*;
    localparam int CW = $clog2(DEPTH + 1);
    rlec_err_type mem_r [DEPTH];
    logic [CW-1:0] count_r;
    wire do_pop = ev.pop && (count_r != '0);
    wire [CW-1:0] base = do_pop ? CW'(count_r - 1'b1) : count_r;
    wire do_push = ev.push && (base < CW'(DEPTH));
    assign ev.head_code = mem_r[0];
    assign ev.head_valid = (count_r != '0);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else begin
            count_r <= CW'(base + CW'(do_push));
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= RLEC_ERR_NONE;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (do_push && (CW'(i) == base)) begin
                    mem_r[i] <= ev.push_code;
                end else if (do_pop) begin
                    mem_r[i] <= (i + 1 < DEPTH) ? mem_r[(i + 1) % DEPTH] : RLEC_ERR_NONE;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- rlec_err_inject.sv ----
// Purpose: inverts bits of the generated stream, once or at a fixed bit rate
// Assumes: one generated bit per cycle with gen_valid high
// Notes: output is the input bit delayed by one cycle
`timescale 1ns/10ps
`default_nettype none
`include "rlec_regs.svh"
module rlec_err_inject #(
    parameter int BITS_PER_ERR = `RLEC_RATE_BITS
) (
    input wire logic clk,
    input wire logic rst_n,
    rlec_evt_if.inj ev,
    input wire logic gen_bit,
    input wire logic gen_valid,
    output logic out_bit,
    output logic out_valid
);
    import rlec_pkg::*;
    localparam int CW = $clog2(BITS_PER_ERR);
    logic [CW-1:0] cnt_r;
    logic single_pend_r;
    wire rate_on = (ev.ins_mode == RLEC_INS_RATE);
    wire rate_hit = rate_on && gen_valid && (cnt_r == CW'(BITS_PER_ERR - 1)); // see RULE_07
    wire single_hit = single_pend_r && gen_valid; // see RULE_06
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (!rate_on) begin
            cnt_r <= '0; // see RULE_05
        end else if (gen_valid) begin
            cnt_r <= rate_hit ? '0 : CW'(cnt_r + 1'b1);
        end
    end
    // a new single request in the consuming cycle is kept, not lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_pend_r <= 1'b0;
        end else begin
            single_pend_r <= ev.single_pulse || (single_pend_r && !single_hit);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_bit <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            out_bit <= gen_bit ^ (rate_hit || single_hit);
            out_valid <= gen_valid;
        end
    end
endmodule
`default_nettype wire

// ---- rlec_core.sv ----
// Purpose: command interpreter for control leads, error insertion and synthesizer frequency
// Assumes: one write or read strobe per cycle, read data the cycle after a read strobe
// Notes: frequency, timing and pattern writes wait for the message-end write
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rlec_regs.svh"

// What this block does
// RULE_01: a modem-ready lead command sets that lead only while the unit acts as DCE.
// RULE_02: a set-ready lead command sets that lead only while the unit acts as DCE.
// RULE_03: a terminal-ready lead command sets that lead only while the unit acts as DTE.
// RULE_04: reading a lead register reports that lead's present on or off state.
// RULE_05: insertion setting off stops every automatic bit error.
// RULE_06: a single insertion command inverts exactly one generated bit.
// RULE_07: the rate setting inverts one bit in every 1000 generated bits until changed.
// RULE_08: a single insertion command also ends a running rate insertion.
// RULE_09: reading the insertion register reports off, single or rate.
// RULE_10: a frequency is accepted only between 0.05 kHz and 15000 kHz inclusive.
// RULE_11: a frequency that conflicts with pattern or timing logs contention and is not applied.
// RULE_12: a frequency command is held until the message end and evaluated only then; the code range-checks it at the write.
// RULE_13: settings held in one message are judged together on their final combination.
// RULE_14: reading the frequency register returns the applied frequency.
// RULE_15: a lead command in the wrong role leaves the lead alone and logs an error.
module rlec_core #(
    parameter int BITS_PER_ERR = `RLEC_RATE_BITS,
    parameter int EBUF_DEPTH = `RLEC_EBUF_DEPTH,
    parameter logic [`RLEC_FREQ_W-1:0] ASYNC_FREQ_MAX = `RLEC_ASYNC_FREQ_MAX
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`RLEC_ADR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic gen_bit,
    input wire logic gen_valid,
    output logic gen_out_bit,
    output logic gen_out_valid,
    output logic modem_ready_lead,
    output logic set_ready_lead,
    output logic term_ready_lead,
    output logic [`RLEC_FREQ_W-1:0] synth_freq,
    output logic timing_sync,
    output logic [1:0] pattern_sel
);
    import rlec_pkg::*;

    localparam int FW = `RLEC_FREQ_W;

    rlec_evt_if ev ();

    // range check of a requested frequency in 10 Hz units
    function automatic logic freq_ok(input logic [FW-1:0] f);
        freq_ok = (f >= `RLEC_FREQ_MIN) && (f <= `RLEC_FREQ_MAX);
    endfunction

    // combinations the synthesizer cannot serve
    function automatic logic contention(input logic [FW-1:0] f, input logic sync,
        input logic [1:0] pat);
        contention = (!sync && (f > ASYNC_FREQ_MAX)) ||
            (!sync && (pat == `RLEC_PAT_SYNC_ONLY));
    endfunction

    // address decode
    wire sel_mr = (addr == `RLEC_ADR_MODEM_READY);
    wire sel_sr = (addr == `RLEC_ADR_SET_READY);
    wire sel_tr = (addr == `RLEC_ADR_TERM_READY);
    wire sel_ins = (addr == `RLEC_ADR_ERR_INSERT);
    wire sel_freq = (addr == `RLEC_ADR_SYNTH_RATE);
    wire sel_tim = (addr == `RLEC_ADR_TIMING);
    wire sel_pat = (addr == `RLEC_ADR_PATTERN);
    wire sel_end = (addr == `RLEC_ADR_MSG_END);
    wire sel_role = (addr == `RLEC_ADR_ROLE);
    wire sel_ebuf = (addr == `RLEC_ADR_ERR_BUF);

    logic role_dte_r;
    rlec_ins_type ins_mode_r;
    rlec_ins_type ins_mode_nxt;
    logic [FW-1:0] freq_pend_r;
    logic freq_pend_v_r;
    logic tim_pend_r;
    logic tim_pend_v_r;
    logic [1:0] pat_pend_r;
    logic pat_pend_v_r;

    // lead writes and role checks
    wire dce_role = !role_dte_r;
    wire wr_mr = wr && sel_mr;
    wire wr_sr = wr && sel_sr;
    wire wr_tr = wr && sel_tr;
    wire wr_role = wr && sel_role;
    wire mr_ok = wr_mr && dce_role; // see RULE_01
    wire sr_ok = wr_sr && dce_role; // see RULE_02
    wire tr_ok = wr_tr && role_dte_r; // see RULE_03
    wire role_bad = (wr_mr && !dce_role) || (wr_sr && !dce_role) ||
        (wr_tr && !role_dte_r); // see RULE_15

    // insertion writes
    wire wr_ins = wr && sel_ins;
    wire [1:0] ins_code = wdata[1:0];
    wire ins_bad = wr_ins && (ins_code != `RLEC_INS_CODE_OFF) &&
        (ins_code != `RLEC_INS_CODE_SINGLE) && (ins_code != `RLEC_INS_CODE_RATE);
    wire ins_single = wr_ins && (ins_code == `RLEC_INS_CODE_SINGLE);

    // deferred settings
    wire wr_freq = wr && sel_freq;
    wire [FW-1:0] freq_req = wdata[FW-1:0];
    wire freq_bad = wr_freq && !freq_ok(freq_req); // see RULE_10
    wire freq_take = wr_freq && !freq_bad;
    wire wr_end = wr && sel_end;
    wire wr_tim = wr && sel_tim;
    wire wr_pat = wr && sel_pat;
    // a setting left unwritten in this message joins the check at its applied value
    wire [FW-1:0] freq_fin = freq_pend_v_r ? freq_pend_r : synth_freq; // see RULE_13
    wire tim_fin = tim_pend_v_r ? tim_pend_r : timing_sync;
    wire [1:0] pat_fin = pat_pend_v_r ? pat_pend_r : pattern_sel;
    wire fin_bad = wr_end && contention(freq_fin, tim_fin, pat_fin); // see RULE_11
    wire fin_apply = wr_end && !fin_bad; // see RULE_12
    wire pend_any = freq_pend_v_r || tim_pend_v_r || pat_pend_v_r;

    // error logging, one entry per cycle; strobes never overlap so causes never collide
    assign ev.push = role_bad || ins_bad || freq_bad || fin_bad;
    assign ev.push_code = role_bad ? RLEC_ERR_ROLE :
        (fin_bad ? RLEC_ERR_CONTENTION : RLEC_ERR_PARAM);
    assign ev.pop = rd && sel_ebuf;
    assign ev.ins_mode = ins_mode_r;
    assign ev.single_pulse = ins_single; // see RULE_06

    // a refused code keeps the present mode; only the error buffer hears of it
    always_comb begin
        ins_mode_nxt = ins_mode_r;
        if (wr_ins) begin
            unique case (ins_code)
                `RLEC_INS_CODE_OFF: ins_mode_nxt = RLEC_INS_OFF; // see RULE_05
                `RLEC_INS_CODE_SINGLE: ins_mode_nxt = RLEC_INS_SINGLE; // see RULE_08
                `RLEC_INS_CODE_RATE: ins_mode_nxt = RLEC_INS_RATE; // see RULE_07
                default: ins_mode_nxt = ins_mode_r;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ins_mode_r <= RLEC_INS_OFF;
        end else begin
            ins_mode_r <= ins_mode_nxt;
        end
    end

    // the role is never deferred, so a lead write right after it already sees the new role
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            role_dte_r <= 1'b0;
        end else if (wr_role) begin
            role_dte_r <= wdata[0];
        end
    end

    // leads move on the write edge; only the synthesizer settings wait for message end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            modem_ready_lead <= 1'b0;
        end else if (mr_ok) begin
            modem_ready_lead <= wdata[0]; // see RULE_01
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            set_ready_lead <= 1'b0;
        end else if (sr_ok) begin
            set_ready_lead <= wdata[0]; // see RULE_02
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            term_ready_lead <= 1'b0;
        end else if (tr_ok) begin
            term_ready_lead <= wdata[0]; // see RULE_03
        end
    end

    // pending settings are discarded at message end, applied or not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_pend_r <= `RLEC_FREQ_RST;
            freq_pend_v_r <= 1'b0;
        end else if (wr_end) begin
            freq_pend_v_r <= 1'b0;
        end else if (freq_take) begin
            freq_pend_r <= freq_req; // see RULE_12
            freq_pend_v_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tim_pend_r <= 1'b0;
            tim_pend_v_r <= 1'b0;
            pat_pend_r <= 2'h0;
            pat_pend_v_r <= 1'b0;
        end else if (wr_end) begin
            tim_pend_v_r <= 1'b0;
            pat_pend_v_r <= 1'b0;
        end else begin
            if (wr_tim) begin
                tim_pend_r <= wdata[0]; // see RULE_13
                tim_pend_v_r <= 1'b1;
            end
            if (wr_pat) begin
                pat_pend_r <= wdata[1:0]; // see RULE_13
                pat_pend_v_r <= 1'b1;
            end
        end
    end

    // a rejected combination keeps all three previous settings, not only the frequency
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            synth_freq <= `RLEC_FREQ_RST;
            timing_sync <= 1'b0;
            pattern_sel <= 2'h0;
        end else if (fin_apply) begin
            synth_freq <= freq_fin; // see RULE_11
            timing_sync <= tim_fin;
            pattern_sel <= pat_fin;
        end
    end

    // read mux; unmapped addresses read zero
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        if (sel_mr) begin
            rmux[0] = modem_ready_lead; // see RULE_04
        end
        if (sel_sr) begin
            rmux[0] = set_ready_lead; // see RULE_04
        end
        if (sel_tr) begin
            rmux[0] = term_ready_lead; // see RULE_04
        end
        if (sel_ins) begin
            rmux[1:0] = (ins_mode_r == RLEC_INS_SINGLE) ? `RLEC_INS_CODE_SINGLE :
                ((ins_mode_r == RLEC_INS_RATE) ? `RLEC_INS_CODE_RATE :
                `RLEC_INS_CODE_OFF); // see RULE_09
        end
        if (sel_freq) begin
            rmux[FW-1:0] = synth_freq; // see RULE_14
        end
        if (sel_tim) begin
            rmux[0] = timing_sync;
        end
        if (sel_pat) begin
            rmux[1:0] = pattern_sel;
        end
        if (sel_end) begin
            rmux[0] = pend_any;
        end
        if (sel_role) begin
            rmux[0] = role_dte_r;
        end
        if (sel_ebuf) begin
            rmux[`RLEC_EBUF_VALID_BIT] = ev.head_valid;
            rmux[1:0] = ev.head_code;
        end
    end

    // rdata falls back to zero so a stale word never looks like a fresh answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd ? rmux : 32'h0000_0000;
        end
    end

    // only one strobe arrives per cycle, so one push a cycle is enough
    rlec_err_buf #(
        .DEPTH(EBUF_DEPTH)
    ) u_ebuf (
        .clk(clk),
        .rst_n(rst_n),
        .ev(ev.ebuf)
    );

    // the stream passes through one flop, so the inverted bit stays aligned with its valid
    rlec_err_inject #(
        .BITS_PER_ERR(BITS_PER_ERR)
    ) u_inj (
        .clk(clk),
        .rst_n(rst_n),
        .ev(ev.inj),
        .gen_bit(gen_bit),
        .gen_valid(gen_valid),
        .out_bit(gen_out_bit),
        .out_valid(gen_out_valid)
    );
endmodule
`default_nettype wire

// ---- rlec_core_sva.sv ----
// Purpose: port-level assertions of the line and error config block
// Assumes: the role is followed from writes to the role register
// Notes: role is not a port, so a shadow copy is kept here
`timescale 1ns/10ps
`default_nettype none
`include "rlec_regs.svh"
module rlec_core_sva #(
    parameter logic [`RLEC_FREQ_W-1:0] ASYNC_FREQ_MAX = `RLEC_ASYNC_FREQ_MAX
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`RLEC_ADR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic gen_valid,
    input wire logic gen_bit,
    input wire logic gen_out_bit,
    input wire logic gen_out_valid,
    input wire logic modem_ready_lead,
    input wire logic set_ready_lead,
    input wire logic term_ready_lead,
    input wire logic [`RLEC_FREQ_W-1:0] synth_freq,
    input wire logic timing_sync,
    input wire logic [1:0] pattern_sel
);
    logic dte_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dte_r <= 1'b0;
        end else if (wr && addr == `RLEC_ADR_ROLE) begin
            dte_r <= wdata[0];
        end
    end
    wire dm_wr_ok = wr && addr == `RLEC_ADR_MODEM_READY && !dte_r;
    wire tr_wr_ok = wr && addr == `RLEC_ADR_TERM_READY && dte_r;
    wire end_wr = wr && addr == `RLEC_ADR_MSG_END;
    wire ins_wr = wr && addr == `RLEC_ADR_ERR_INSERT;
    logic ins_off_r;
    logic sgl_pend_r;
    // shadow of the insertion setting and of a single error not yet spent
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ins_off_r <= 1'b1;
            sgl_pend_r <= 1'b0;
        end else begin
            if (ins_wr && wdata[1:0] != 2'h3) begin
                ins_off_r <= (wdata[1:0] == `RLEC_INS_CODE_OFF);
            end
            sgl_pend_r <= (ins_wr && wdata[1:0] == `RLEC_INS_CODE_SINGLE) ||
                (sgl_pend_r && !gen_valid);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    dm_set_a: assert property (wr && addr == `RLEC_ADR_MODEM_READY && !dte_r
        |=> modem_ready_lead == $past(wdata[0])) else $error("dm lead not set");
    dsr_set_a: assert property (wr && addr == `RLEC_ADR_SET_READY && !dte_r
        |=> set_ready_lead == $past(wdata[0])) else $error("dsr lead not set");
    tr_set_a: assert property (wr && addr == `RLEC_ADR_TERM_READY && dte_r
        |=> term_ready_lead == $past(wdata[0])) else $error("tr lead not set");
    dm_hold_a: assert property ($changed(modem_ready_lead)
        |-> $past(dm_wr_ok)) else $error("dm moved");
    tr_hold_a: assert property ($changed(term_ready_lead)
        |-> $past(tr_wr_ok)) else $error("tr moved");
    lead_read_a: assert property (rd && addr == `RLEC_ADR_MODEM_READY
        |=> rdata == {31'h0, $past(modem_ready_lead)}) else $error("dm read wrong");
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("rdata not idle");
    freq_range_a: assert property (synth_freq >= `RLEC_FREQ_MIN
        && synth_freq <= `RLEC_FREQ_MAX) else $error("freq out of range");
    freq_defer_a: assert property ($changed(synth_freq)
        |-> $past(end_wr)) else $error("freq applied early");
    async_ok_a: assert property (!timing_sync |-> synth_freq <= ASYNC_FREQ_MAX
        && pattern_sel != `RLEC_PAT_SYNC_ONLY) else $error("contention applied");
    freq_read_a: assert property (rd && addr == `RLEC_ADR_SYNTH_RATE
        |=> rdata == {8'h0, $past(synth_freq)}) else $error("freq read wrong");
    gen_pass_a: assert property (1'b1 |=> gen_out_valid == $past(gen_valid))
        else $error("gen valid not delayed");
    off_clean_a: assert property (ins_off_r && !sgl_pend_r && gen_valid
        |=> gen_out_bit == $past(gen_bit)) else $error("bit inverted while off");
    cover property (wr && addr == `RLEC_ADR_ROLE && wdata[0]);
    cover property ($changed(synth_freq));
    cover property (gen_out_valid && gen_out_bit);
endmodule
bind rlec_core rlec_core_sva #(.ASYNC_FREQ_MAX(ASYNC_FREQ_MAX)) u_rlec_core_sva (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .gen_valid(gen_valid), .gen_bit(gen_bit), .gen_out_bit(gen_out_bit),
    .gen_out_valid(gen_out_valid),
    .modem_ready_lead(modem_ready_lead), .set_ready_lead(set_ready_lead),
    .term_ready_lead(term_ready_lead), .synth_freq(synth_freq), .timing_sync(timing_sync),
    .pattern_sel(pattern_sel));
`default_nettype wire

// ---- rlec_host.sv ----
// Purpose: remote controller model driving the register port
// Assumes: read data stand only in the cycle after the read strobe
// Notes: address is inverted after every access and data after a write so stale values never look valid
`timescale 1ns/10ps
`default_nettype none
module rlec_host (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [31:0] rdata
);
    initial begin
        addr = 8'hff;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ---- rlec_core_tb.sv ----
// Purpose: self-checking bench of the line and error config block
// Assumes: rate insertion shortened to one error per 10 bits
// Notes: the host model owns the register port, the bench owns the stream
`timescale 1ns/10ps
`default_nettype none
`include "rlec_regs.svh"
module rlec_core_tb;
    import rlec_pkg::*;
    logic clk, rst_n, wr, rd, gen_bit, gen_valid, gen_out_bit, gen_out_valid;
    logic dm, dsr, tr, tsync;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [23:0] freq;
    logic [1:0] pat;
    int fails, n_checks;
    rlec_host u_rlec_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    rlec_core #(.BITS_PER_ERR(10)) u_rlec_core (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gen_bit(gen_bit),
        .gen_valid(gen_valid), .gen_out_bit(gen_out_bit), .gen_out_valid(gen_out_valid),
        .modem_ready_lead(dm), .set_ready_lead(dsr), .term_ready_lead(tr),
        .synth_freq(freq), .timing_sync(tsync), .pattern_sel(pat));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic end_sim();
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        u_rlec_host.wr_reg(a, d);
    endtask
    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        u_rlec_host.rd_reg(a, d);
        chk(what, exp, d);
    endtask
    task automatic ec(input rlec_err_type c);
        rc("err buf", `RLEC_ADR_ERR_BUF, {23'h0, 1'b1, 6'h0, c});
    endtask
    // drives n alternating bits and counts outputs that differ from the bit sent
    task automatic bits(input int n, input int exp);
        int cnt;
        logic pb;
        cnt = 0;
        pb = 1'b0;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            gen_valid <= (i < n);
            gen_bit <= i[0];
            #1;
            if (gen_out_valid === 1'b1 && gen_out_bit !== pb) cnt++;
            pb = i[0];
        end
        chk("inverted bits", exp, cnt);
    endtask
    initial begin
        #(20000 * 5);
        fails++;
        end_sim();
    end
    initial begin
        fails = 0;
        n_checks = 0;
        rst_n = 1'b0;
        gen_bit = 1'b0;
        gen_valid = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rc("freq rst", `RLEC_ADR_SYNTH_RATE, 32'h3c0);
        rc("dm rst", `RLEC_ADR_MODEM_READY, 32'h0);
        rc("ins rst", `RLEC_ADR_ERR_INSERT, 32'h0);
        rc("unmapped", 8'h30, 32'h0);
        w(`RLEC_ADR_MODEM_READY, 32'h1);
        chk("dm", 32'h1, {31'h0, dm});
        rc("dm rd", `RLEC_ADR_MODEM_READY, 32'h1);
        w(`RLEC_ADR_SET_READY, 32'h1);
        rc("dsr rd", `RLEC_ADR_SET_READY, 32'h1);
        w(`RLEC_ADR_TERM_READY, 32'h1);
        chk("tr dce", 32'h0, {31'h0, tr});
        ec(RLEC_ERR_ROLE);
        w(`RLEC_ADR_ROLE, 32'h1);
        w(`RLEC_ADR_TERM_READY, 32'h1);
        rc("tr rd", `RLEC_ADR_TERM_READY, 32'h1);
        w(`RLEC_ADR_MODEM_READY, 32'h0);
        chk("dm dte", 32'h1, {31'h0, dm});
        ec(RLEC_ERR_ROLE);
        w(`RLEC_ADR_ROLE, 32'h0);
        w(`RLEC_ADR_SET_READY, 32'h0);
        chk("dsr off", 32'h0, {31'h0, dsr});
        bits(30, 0);
        w(`RLEC_ADR_ERR_INSERT, 32'h2);
        rc("ins rate", `RLEC_ADR_ERR_INSERT, 32'h2);
        bits(30, 3);
        w(`RLEC_ADR_ERR_INSERT, 32'h1);
        rc("ins single", `RLEC_ADR_ERR_INSERT, 32'h1);
        bits(30, 1);
        w(`RLEC_ADR_ERR_INSERT, 32'h3);
        ec(RLEC_ERR_PARAM);
        rc("ins kept", `RLEC_ADR_ERR_INSERT, 32'h1);
        w(`RLEC_ADR_ERR_INSERT, 32'h2);
        bits(5, 0);
        w(`RLEC_ADR_ERR_INSERT, 32'h0);
        rc("ins off", `RLEC_ADR_ERR_INSERT, 32'h0);
        bits(30, 0);
        w(`RLEC_ADR_SYNTH_RATE, 32'h4);
        ec(RLEC_ERR_PARAM);
        w(`RLEC_ADR_SYNTH_RATE, 32'h5);
        rc("freq held", `RLEC_ADR_SYNTH_RATE, 32'h3c0);
        rc("pending", `RLEC_ADR_MSG_END, 32'h1);
        w(`RLEC_ADR_MSG_END, 32'h0);
        rc("freq min", `RLEC_ADR_SYNTH_RATE, 32'h5);
        w(`RLEC_ADR_SYNTH_RATE, 32'h16e360);
        w(`RLEC_ADR_TIMING, 32'h1);
        w(`RLEC_ADR_MSG_END, 32'h0);
        rc("freq max", `RLEC_ADR_SYNTH_RATE, 32'h16e360);
        w(`RLEC_ADR_SYNTH_RATE, 32'h16e361);
        ec(RLEC_ERR_PARAM);
        w(`RLEC_ADR_TIMING, 32'h0);
        w(`RLEC_ADR_MSG_END, 32'h0);
        ec(RLEC_ERR_CONTENTION);
        chk("sync kept", 32'h1, {31'h0, tsync});
        rc("freq kept", `RLEC_ADR_SYNTH_RATE, 32'h16e360);
        w(`RLEC_ADR_SYNTH_RATE, 32'h0f4240);
        w(`RLEC_ADR_TIMING, 32'h0);
        w(`RLEC_ADR_MSG_END, 32'h0);
        rc("freq async", `RLEC_ADR_SYNTH_RATE, 32'h0f4240);
        rc("no error", `RLEC_ADR_ERR_BUF, 32'h0);
        w(`RLEC_ADR_PATTERN, 32'h3);
        w(`RLEC_ADR_MSG_END, 32'h0);
        ec(RLEC_ERR_CONTENTION);
        chk("pattern kept", 32'h0, {30'h0, pat});
        end_sim();
    end
endmodule
`default_nettype wire
